// ---- rtl/acs_device.sv ----
// Converter control end: framing, sequencer, power modes
module acs_device
  import acs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  acs_link_if.dev link,
  input wire logic [11:0] sample_data,
  output logic [3:0] conv_addr,
  output logic track_hold,
  output logic conv_start,
  output logic sample_take,
  output logic [14:0] ctrl_word,
  output logic part_pd,
  output logic temp_avg_clear,
  output logic seq_armed
);

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [8:0] mask_of(input logic [14:0] cw);
    mask_of = {cw[CW_TEMP_SENSOR_SELECT], cw[CW_CH_HI:CW_CH_LO]};
  endfunction

  // Lowest selected source at or above from; bit 4 says found
  function automatic logic [4:0] find_sel(input logic [8:0] mask, input logic [3:0] from);
    logic found;
    logic [3:0] idx;
    found = 1'b0;
    idx = 4'h0;
    for (int i = 0; i < 9; i++) begin
      if (!found && (4'(i) >= from) && mask[i]) begin
        found = 1'b1;
        idx = 4'(i);
      end
    end
    find_sel = {found, idx};
  endfunction

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [2:0] pin_in;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] filt;
  logic [2:0] filt_d;

  assign pin_in = {link.cs_n, link.sclk, link.din};

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= PIN_IDLE;
      sync2 <= PIN_IDLE;
      sync3 <= PIN_IDLE;
      filt <= PIN_IDLE;
      filt_d <= PIN_IDLE;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      // A change counts only once stages two and three agree
      filt <= ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
      filt_d <= filt;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sck_fall;
  logic sck_rise;

  assign cs_fall = filt_d[2] & ~filt[2];
  assign cs_rise = ~filt_d[2] & filt[2];
  assign sck_fall = filt_d[1] & ~filt[1] & ~filt[2];
  assign sck_rise = ~filt_d[1] & filt[1] & ~filt[2];

  // ****************************************************
  // Shift-in framing
  // ****************************************************
  logic [4:0] fall_cnt;
  logic [15:0] in_sr;
  logic [4:0] next_fall_cnt;

  assign next_fall_cnt = (fall_cnt == 5'h1F) ? fall_cnt : fall_cnt + 5'h01;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fall_cnt <= 5'h00;
      in_sr <= 16'h0000;
    end else if (cs_fall) begin
      fall_cnt <= 5'h00;
    end else if (sck_fall) begin
      fall_cnt <= next_fall_cnt;
      if (fall_cnt < FULL_FALLS) begin
        in_sr <= {in_sr[14:0], filt[0]}; // RULE12
      end
    end
  end

  logic frame_full;
  logic write_ok;
  logic [14:0] new_cw;

  assign frame_full = cs_rise && (fall_cnt >= FULL_FALLS); // RULE12 RULE17
  assign write_ok = frame_full && in_sr[CW_WRITE]; // RULE22
  assign new_cw = in_sr[14:0];

  // ****************************************************
  // Sequencer, control word and power state
  // ****************************************************
  logic [3:0] seq_ptr;
  logic start_conv;
  logic [4:0] seq_next;
  logic [4:0] seq_wrap;
  logic [4:0] wr_first;

  assign start_conv = cs_fall && !part_pd && seq_armed; // RULE3
  assign seq_next = find_sel(mask_of(ctrl_word), seq_ptr + 4'h1); // RULE4 RULE7
  assign seq_wrap = find_sel(mask_of(ctrl_word), 4'h0); // RULE6
  assign wr_first = find_sel(mask_of(new_cw), 4'h0);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_word <= CTRL_RESET;
      seq_ptr <= 4'h0;
      seq_armed <= 1'b0;
      part_pd <= 1'b0;
      temp_avg_clear <= 1'b0;
    end else begin
      temp_avg_clear <= 1'b0;
      if (start_conv) begin
        if (seq_next[4]) begin
          seq_ptr <= seq_next[3:0]; // RULE4
        end else if (ctrl_word[CW_REPEAT]) begin
          seq_ptr <= seq_wrap[3:0]; // RULE6
        end else begin
          seq_armed <= 1'b0; // RULE5
        end
      end
      if (write_ok) begin
        ctrl_word <= new_cw; // RULE22
        seq_ptr <= wr_first[3:0]; // RULE9
        seq_armed <= wr_first[4];
        if (new_cw[CW_PD] && !part_pd) begin
          part_pd <= 1'b1; // RULE17
          temp_avg_clear <= new_cw[CW_TAVG]; // RULE19
        end else if (!new_cw[CW_PD] && part_pd) begin
          // Waking write is not a configuration; wait for the next one
          part_pd <= 1'b0; // RULE20 RULE21
          seq_armed <= 1'b0;
        end else begin
          part_pd <= new_cw[CW_PD]; // RULE13
        end
      end
    end
  end

  // ****************************************************
  // Conversion and track-and-hold
  // ****************************************************
  logic conv_active;
  logic [15:0] res_word;
  logic res_valid;
  logic [3:0] start_addr;

  always_comb begin
    if (seq_ptr == TEMP_IDX && ctrl_word[CW_TAVG]) begin
      start_addr = ADDR_TEMP_AVG;
    end else begin
      start_addr = seq_ptr;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_active <= 1'b0;
      conv_addr <= 4'h0;
      track_hold <= 1'b0;
      conv_start <= 1'b0;
      sample_take <= 1'b0;
      res_word <= NO_RESULT;
      res_valid <= 1'b0;
    end else begin
      conv_start <= start_conv;
      sample_take <= 1'b0;
      if (cs_fall) begin
        res_valid <= 1'b0;
      end
      if (start_conv) begin
        conv_active <= 1'b1;
        conv_addr <= start_addr;
        track_hold <= 1'b1; // RULE11
      end else if (sck_fall && conv_active && next_fall_cnt == HOLD_END_FALL) begin
        track_hold <= 1'b0; // RULE11
        conv_active <= 1'b0;
        sample_take <= 1'b1;
        res_word <= {conv_addr, sample_data}; // RULE23
        res_valid <= 1'b1;
      end else if (cs_rise && conv_active) begin
        // Frame ended early: conversion is lost
        conv_active <= 1'b0;
        track_hold <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Shift-out path
  // ****************************************************
  logic [15:0] out_sr;
  logic [15:0] load_word;

  always_comb begin
    if (part_pd) begin
      load_word = PD_ONES; // RULE18
    end else if (res_valid) begin
      load_word = res_word; // RULE3
    end else begin
      load_word = NO_RESULT; // RULE2
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_sr <= 16'h0000;
      link.dout <= 1'b0;
      link.dout_oe <= 1'b0;
    end else if (cs_fall) begin
      out_sr <= load_word;
      link.dout <= load_word[15];
      link.dout_oe <= 1'b1;
    end else if (cs_rise) begin
      link.dout <= 1'b0;
      link.dout_oe <= 1'b0;
    end else if (sck_rise) begin
      out_sr <= {out_sr[14:0], part_pd};
      link.dout <= out_sr[14];
    end
  end

endmodule

// ---- rtl/acs_host.sv ----
// Serial master end: APB registers and link sequencer
module acs_host
  import acs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  acs_link_if.host link
);

  typedef enum {
    ST_IDLE,
    ST_LEAD,
    ST_HIGH,
    ST_LOW,
    ST_TAIL,
    ST_QUIET
  } acs_host_state_type;

  acs_host_state_type state;
  logic [15:0] tx_word;
  logic [15:0] rx_word;
  logic rx_new;
  logic busy;
  logic start;

  assign busy = (state != ST_IDLE);

  // ****************************************************
  // APB slave
  // ****************************************************
  logic setup;
  logic done;
  logic mapped;
  logic tx_refused;

  assign setup = psel && !penable;
  assign done = psel && penable && pready;
  assign mapped = (paddr == REG_TX) || (paddr == REG_RX) || (paddr == REG_STATUS);
  assign tx_refused = pwrite && (paddr == REG_TX) && (busy || start);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup && !pready;
      pslverr <= setup && (!mapped || tx_refused);
      if (setup) begin
        case (paddr)
          REG_TX: prdata <= {16'h0000, tx_word};
          REG_RX: prdata <= {16'h0000, rx_word};
          REG_STATUS: prdata <= {30'h0000_0000, rx_new, busy};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  logic frame_end;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_word <= 16'h0000;
      start <= 1'b0;
      rx_new <= 1'b0;
    end else begin
      if (state == ST_IDLE) begin
        start <= 1'b0;
      end
      // Software owns the word content, repeat and write bits included
      if (done && pwrite && paddr == REG_TX && !pslverr) begin
        tx_word <= pwdata[15:0]; // RULE1 RULE8 RULE10
        start <= 1'b1;
      end
      if (frame_end) begin
        rx_new <= 1'b1;
      end else if (done && !pwrite && paddr == REG_RX) begin
        rx_new <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Returned data synchroniser
  // ****************************************************
  logic dsync1;
  logic dsync2;
  logic dsync3;
  logic dfilt;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dsync1 <= 1'b0;
      dsync2 <= 1'b0;
      dsync3 <= 1'b0;
      dfilt <= 1'b0;
    end else begin
      dsync1 <= link.dout_line;
      dsync2 <= dsync1;
      dsync3 <= dsync2;
      if (dsync2 == dsync3) begin
        dfilt <= dsync3;
      end
    end
  end

  // ****************************************************
  // Link sequencer
  // ****************************************************
  logic [7:0] cnt;
  logic [4:0] bit_cnt;
  logic [15:0] sh_out;
  logic [15:0] sh_in;
  logic half_done;

  assign half_done = (cnt == SCLK_HALF_CYC - 8'h01);
  assign frame_end = (state == ST_TAIL) && half_done;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      cnt <= 8'h00;
      bit_cnt <= 5'h00;
      sh_out <= 16'h0000;
      sh_in <= 16'h0000;
      rx_word <= 16'h0000;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b1;
      link.din <= 1'b0;
    end else begin
      cnt <= cnt + 8'h01;
      case (state)
        ST_IDLE: begin
          cnt <= 8'h00;
          if (start) begin
            link.cs_n <= 1'b0;
            link.din <= tx_word[15];
            sh_out <= {tx_word[14:0], 1'b0};
            bit_cnt <= 5'h00;
            state <= ST_LEAD;
          end
        end
        ST_LEAD, ST_HIGH: begin
          if (half_done) begin
            cnt <= 8'h00;
            link.sclk <= 1'b0;
            sh_in <= {sh_in[14:0], dfilt};
            state <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (half_done) begin
            cnt <= 8'h00;
            link.sclk <= 1'b1;
            link.din <= sh_out[15];
            sh_out <= {sh_out[14:0], 1'b0};
            bit_cnt <= bit_cnt + 5'h01;
            // Full frame is far longer than the least sample period
            if (bit_cnt == FULL_FALLS - 5'h01) begin
              state <= ST_TAIL; // RULE14 RULE15
            end else begin
              state <= ST_HIGH;
            end
          end
        end
        ST_TAIL: begin
          if (half_done) begin
            cnt <= 8'h00;
            link.cs_n <= 1'b1;
            link.din <= 1'b0;
            rx_word <= sh_in;
            state <= ST_QUIET;
          end
        end
        ST_QUIET: begin
          if (cnt == QUIET_CYC - 8'h01) begin
            state <= ST_IDLE; // RULE16 RULE21
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- rtl/acs_link_if.sv ----
// Four-wire serial link between host and converter
interface acs_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic dout_line;

  // Undriven data line reads low
  assign dout_line = dout_oe ? dout : 1'b0;

  modport dev(input cs_n, input sclk, input din, output dout, output dout_oe);
  modport host(output cs_n, output sclk, output din, input dout_line);
endinterface

// ---- rtl/acs_pkg.sv ----
// Constants shared by both ends of the converter serial link
//
// Summary of operation
// RULE1: Host programs control word before any conversion
// RULE2: Output during first configuration write is invalid
// RULE3: Write, then convert, result in third transfer
// RULE4: Multiple channels converted once, ascending, per edge
// RULE5: Non-repeat sequence stops until new control write
// RULE6: Repeat wraps from last to first selected
// RULE7: Temperature converts after last analog channel
// RULE8: Host keeps write bit zero during repeat
// RULE9: Any accepted write restarts sequence at first
// RULE10: Host clears repeat bit to leave repeat
// RULE11: Hold at select fall, track at 14th fall
// RULE12: First 16 input bits load only when write set
// RULE13: Power-down bit zero keeps device fully powered
// RULE14: Host gives sixteen serial clocks per transfer
// RULE15: Host stays at or below one megasample rate
// RULE16: Host waits quiet time before next select fall
// RULE17: Completed write with power-down enters partial power-down
// RULE18: Partial power-down shifts out all ones
// RULE19: Entering power-down clears temperature average; here only when the power-down write sets CW_TAVG
// RULE20: Write clearing power-down wakes at select rise
// RULE21: After wake, configure first; result in fourth
// RULE22: Bit 15 is write enable for 15 bits
// RULE23: Channel address precedes the 12 result bits
package acs_pkg;

  // ****************************************************
  // Control word layout
  // ****************************************************
  localparam int WORD_BITS = 16;
  localparam int CW_WRITE = 15;
  localparam int CW_REPEAT = 14;
  localparam int CW_CH_HI = 13;
  localparam int CW_CH_LO = 6;
  localparam int CW_TEMP_SENSOR_SELECT = 5;
  localparam int CW_EXT_REF = 3;
  localparam int CW_TAVG = 2;
  localparam int CW_PD = 1;
  localparam logic [14:0] CTRL_RESET = 15'h0000;

  // ****************************************************
  // Sequencer and output word
  // ****************************************************
  localparam logic [3:0] TEMP_IDX = 4'h8;
  localparam logic [3:0] ADDR_TEMP_AVG = 4'h9;
  localparam logic [4:0] HOLD_END_FALL = 5'h0E;
  localparam logic [4:0] FULL_FALLS = 5'h10;
  localparam logic [15:0] PD_ONES = 16'hFFFF;
  localparam logic [15:0] NO_RESULT = 16'h0000;
  // Sync reset values for cs_n, sclk, din
  localparam logic [2:0] PIN_IDLE = 3'h6;

  // ****************************************************
  // Host timing
  // ****************************************************
  localparam int SYS_CLK_NS = 50;
  localparam int QUIET_TIME_NS = 100;
  localparam int MIN_FRAME_NS = 1000;
  localparam logic [7:0] SCLK_HALF_CYC = 8'h0C;
  localparam logic [7:0] QUIET_CYC = 8'((QUIET_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
  localparam logic [15:0] MIN_FRAME_CYC = 16'((MIN_FRAME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

  // ****************************************************
  // Host register map (APB byte addresses)
  // ****************************************************
  localparam logic [7:0] REG_TX = 8'h00;
  localparam logic [7:0] REG_RX = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int ST_BUSY = 0;
  localparam int ST_RX_NEW = 1;

endpackage

// ---- testbench/acs_link_props.sv ----
// Concurrent checks on the serial link and the converter control outputs
module acs_link_props
  import acs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic conv_start,
  input wire logic sample_take,
  input wire logic track_hold,
  input wire logic [14:0] ctrl_word,
  input wire logic part_pd,
  input wire logic temp_avg_clear
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // ****************************************************
  // Power modes
  // ****************************************************
  chk_pd_all_ones: assert property (part_pd && !cs_n && dout_oe |-> dout)
    else $error("data line low while powered down");
  chk_pd_no_conv: assert property (part_pd |-> !conv_start && !track_hold)
    else $error("conversion activity while powered down");
  chk_pd_at_rise: assert property ($changed(part_pd) |-> cs_n)
    else $error("power state changed inside a frame");
  chk_avg_clear_cause: assert property (temp_avg_clear |-> part_pd && ctrl_word[CW_TAVG])
    else $error("average cleared without entering power-down");

  // ****************************************************
  // Framing and conversion timing
  // ****************************************************
  // Control word only settles after the frame closes
  chk_ctrl_after_frame: assert property ($changed(ctrl_word) |-> cs_n)
    else $error("control word changed inside a frame");
  chk_hold_in_frame: assert property ($rose(track_hold) |-> !cs_n)
    else $error("hold entered outside a frame");
  chk_take_from_hold: assert property (sample_take |-> $past(track_hold))
    else $error("sample taken without hold");
  chk_start_in_frame: assert property (conv_start |-> !cs_n)
    else $error("conversion started outside a frame");
  chk_sclk_idle_high: assert property (cs_n |-> sclk)
    else $error("serial clock low while deselected");
  chk_dout_released: assert property (cs_n [*6] |-> !dout_oe)
    else $error("data line driven while deselected");
endmodule

// ---- testbench/adc_channel_sequencer_power_modes_tb.sv ----
// Bench joining host and converter ends, driven over APB
module adc_channel_sequencer_power_modes_tb
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [15:0] tx;
    logic [11:0] samp;
    logic [15:0] rx;
  } acs_row_type;

  // ****************************************************
  // Frame table: word sent, sample offered, word expected
  // ****************************************************
  localparam acs_row_type rows [16] = '{
    '{16'h8140, 12'h000, 16'h0000}, '{16'h7FFE, 12'h111, 16'h0000},
    '{16'h0000, 12'h222, 16'h0111}, '{16'h0000, 12'h333, 16'h2222},
    '{16'h0000, 12'h444, 16'h0000}, '{16'hC0A0, 12'h555, 16'h0000},
    '{16'h0000, 12'h666, 16'h0000}, '{16'h0000, 12'h777, 16'h1666},
    '{16'hC0A0, 12'h888, 16'h8777}, '{16'h0000, 12'h999, 16'h1888},
    '{16'hA006, 12'hAAA, 16'h1999}, '{16'h0000, 12'hBBB, 16'hFFFF},
    '{16'h8040, 12'hCCC, 16'hFFFF}, '{16'h8040, 12'hDDD, 16'h0000},
    '{16'h0000, 12'hEEE, 16'h0000}, '{16'h0000, 12'hFFF, 16'h0EEE}};

  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [11:0] sample_data = 12'h000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] conv_addr;
  logic track_hold;
  logic conv_start;
  logic sample_take;
  logic [14:0] ctrl_word;
  logic part_pd;
  logic temp_avg_clear;
  logic seq_armed;
  logic avg_seen = 1'b0;
  logic [31:0] q;
  logic e;
  int fails = 0;
  int samples_checked = 0;
  int falls_seen = 0;

  acs_link_if link();

  acs_host i_acs_host(.sys_clk(sys_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));

  acs_device i_acs_device(.sys_clk(sys_clk), .arst_n(arst_n), .link(link),
    .sample_data(sample_data), .conv_addr(conv_addr), .track_hold(track_hold),
    .conv_start(conv_start), .sample_take(sample_take), .ctrl_word(ctrl_word),
    .part_pd(part_pd), .temp_avg_clear(temp_avg_clear), .seq_armed(seq_armed));

  acs_link_props i_acs_link_props(.sys_clk(sys_clk), .arst_n(arst_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .dout(link.dout), .dout_oe(link.dout_oe), .conv_start(conv_start),
    .sample_take(sample_take), .track_hold(track_hold), .ctrl_word(ctrl_word),
    .part_pd(part_pd), .temp_avg_clear(temp_avg_clear));

  always #25 sys_clk = ~sys_clk;

  // Counts serial clock falls of the current frame on the wire itself
  always @(negedge link.cs_n or negedge link.sclk) begin
    if (link.sclk) begin
      falls_seen = 0;
    end else begin
      falls_seen++;
    end
  end

  always @(posedge sys_clk) begin
    if (temp_avg_clear === 1'b1) avg_seen <= 1'b1;
  end

  task automatic close_out;
    $display("checked %0d, failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No cycle count is assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded status poll; the final compare flags a hang
  task automatic wait_bit(input int idx, input logic val);
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0000_0000, q, e);
      n++;
    end while (q[idx] !== val && n < 300);
    check({31'h0, q[idx]}, {31'h0, val});
  endtask

  task automatic frame(input acs_row_type r);
    sample_data <= r.samp;
    wait_bit(ST_BUSY, 1'b0);
    apb(1'b1, REG_TX, {16'h0000, r.tx}, q, e);
    wait_bit(ST_RX_NEW, 1'b1);
    apb(1'b0, REG_RX, 32'h0000_0000, q, e);
    check(q, {16'h0000, r.rx});
    check(32'(falls_seen), 32'h0000_0010);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      frame(rows[i]);
      if (i == 4) check({31'h0, seq_armed}, 32'h0000_0000);
      if (i == 7) check({28'h0, conv_addr}, {28'h0, TEMP_IDX});
      if (i == 9) check({31'h0, seq_armed}, 32'h0000_0001);
    end
    check({28'h0, conv_addr}, 32'h0000_0000);
    check({31'h0, seq_armed}, 32'h0000_0000);
    check({17'h0, ctrl_word}, 32'h0000_0040);
    check({31'h0, part_pd}, 32'h0000_0000);
    check({31'h0, avg_seen}, 32'h0000_0001);
    apb(1'b0, 8'h0C, 32'h0000_0000, q, e);
    check({31'h0, e}, 32'h0000_0001);
    // Second start while one is pending must be refused
    wait_bit(ST_BUSY, 1'b0);
    apb(1'b1, REG_TX, 32'h0000_0000, q, e);
    apb(1'b1, REG_TX, 32'h0000_0000, q, e);
    check({31'h0, e}, 32'h0000_0001);
    // Reset in mid-frame, then configure from scratch
    repeat (40) @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check({31'h0, link.cs_n}, 32'h0000_0001);
    check({17'h0, ctrl_word}, {17'h0, CTRL_RESET});
    arst_n <= 1'b1;
    @(posedge sys_clk);
    frame(rows[0]);
    close_out;
  end

  initial begin
    #1_500_000;
    fails++;
    close_out;
  end
endmodule
